// File: inc/spi_port_defs.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// register select codes on the cpu i/o port
`define SPI_REG_CTRL      2'h0
`define SPI_REG_STATUS    2'h1
`define SPI_REG_DATA      2'h2

// control register fields
`define SPI_CTRL_IRQ_EN   7
`define SPI_CTRL_PORT_EN  6
`define SPI_CTRL_ORDER    5
`define SPI_CTRL_MASTER   4
`define SPI_CTRL_CLOCK_IDLE_LEVEL     3
`define SPI_CTRL_CLOCK_SAMPLE_PHASE     2
`define SPI_CTRL_RATE_HI  1
`define SPI_CTRL_RATE_LO  0
`define SPI_CTRL_RESET    8'h00

// status register fields
`define SPI_STAT_DONE     7
`define SPI_STAT_WRITE_COLLISION_FLAG     6
`define SPI_STAT_DBL      0

// sck divisors of the system clock at normal speed; double speed halves them
`define SPI_DIV_RATE0     8'h04
`define SPI_DIV_RATE1     8'h10
`define SPI_DIV_RATE2     8'h40
`define SPI_DIV_RATE3     8'h80

// last bit index and last sck edge index of a byte
`define SPI_BITS_LAST     3'h7
`define SPI_EDGE_LAST     4'hF

`endif

// File: inc/spi_port_pkg.sv
// types shared by the serial port files
package spi_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_M_WAIT   = 2'b01,
    ST_M_SHIFT  = 2'b10,
    ST_S_ACTIVE = 2'b11
  } spi_state_t;

endpackage

// File: rtl/byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  // a push into a full buffer is taken when the same cycle pops
  always_comb begin
    pop   = out_valid && out_ready;
    push  = in_valid && (in_ready || pop);
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule // byte_fifo

// File: rtl/spi_master_slave_port.sv
// byte-wide serial peripheral port, master or slave, with cpu register interface
`timescale 1ns/1ps
`include "spi_port_defs.svh"

module spi_master_slave_port #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // cpu register port
  input  wire logic [1:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // interrupt
  input  wire logic       global_irq_en,
  input  wire logic       irq_ack,
  output logic            irq,
  // user pin directions, one means output
  input  wire logic       mosi_dir,
  input  wire logic       miso_dir,
  input  wire logic       sck_dir,
  input  wire logic       ss_dir,
  input  wire logic       ss_gpio_out,
  // mosi pin
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  // miso pin
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  // sck pin
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  // slave select pin
  input  wire logic       ss_n_i,
  output logic            ss_n_o,
  output logic            ss_n_oe
);

  spi_port_pkg::spi_state_t state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic       dbl_q, dbl_d;
  logic       done_q, done_d;
  logic       write_collision_flag_q, write_collision_flag_d;
  logic       done_arm_q, done_arm_d;
  logic       write_collision_flag_arm_q, write_collision_flag_arm_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_hold_q, tx_hold_d;
  logic [7:0] last_rx_q, last_rx_d;
  logic       out_q, out_d;
  logic       sck_q, sck_d;
  logic       sck_prev_q, sck_prev_d;
  logic [6:0] div_q, div_d;
  logic [3:0] edge_q, edge_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] rdata_q, rdata_d;

  logic       byte_done;
  logic       fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;

  logic       enabled, master, lsb_first, clock_idle_level, clock_sample_phase, busy, forced_slave;
  logic       ctrl_wr, stat_wr, stat_rd, data_wr, data_rd;
  logic       sample, leading, rd_pop;

  // next bit to send, taken from the end that leaves first
  function automatic logic head_bit(input logic [7:0] v, input logic lsb);
    head_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // system cycles per sck half period
  function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
    logic [7:0] div;
    div = `SPI_DIV_RATE0;
    case (rate)
      2'h0:    div = `SPI_DIV_RATE0;
      2'h1:    div = `SPI_DIV_RATE1;
      2'h2:    div = `SPI_DIV_RATE2;
      2'h3:    div = `SPI_DIV_RATE3;
      default: div = `SPI_DIV_RATE0;
    endcase
    half_period = dbl ? {1'b0, div[7:2]} : div[7:1];
  endfunction

  assign enabled   = ctrl_q[`SPI_CTRL_PORT_EN];
  assign master    = ctrl_q[`SPI_CTRL_MASTER];
  assign lsb_first = ctrl_q[`SPI_CTRL_ORDER];
  assign clock_idle_level      = ctrl_q[`SPI_CTRL_CLOCK_IDLE_LEVEL];
  assign clock_sample_phase      = ctrl_q[`SPI_CTRL_CLOCK_SAMPLE_PHASE];
  assign ctrl_wr   = reg_wr && (reg_addr == `SPI_REG_CTRL);
  assign stat_wr   = reg_wr && (reg_addr == `SPI_REG_STATUS);
  assign stat_rd   = reg_rd && (reg_addr == `SPI_REG_STATUS);
  assign data_wr   = reg_wr && (reg_addr == `SPI_REG_DATA);
  assign data_rd   = reg_rd && (reg_addr == `SPI_REG_DATA);

  // a slave byte is only in flight once its first bit was sampled
  assign busy = (state_q == spi_port_pkg::ST_M_WAIT) || (state_q == spi_port_pkg::ST_M_SHIFT) ||
                ((state_q == spi_port_pkg::ST_S_ACTIVE) && (bit_q != 3'h0));

  // another master pulls our select input low
  assign forced_slave = enabled && master && !ss_dir && !ss_n_i;

  // slave cannot stall the far master, so a full buffer drops its oldest byte
  assign rd_pop         = data_rd && fifo_out_valid;
  assign fifo_out_ready = rd_pop || (byte_done && !fifo_in_ready);

  byte_fifo #(.WIDTH (8), .DEPTH (FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (byte_done),
    .in_ready  (fifo_in_ready),
    .in_data   (sh_d),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    state_d    = state_q;
    ctrl_d     = ctrl_q;
    dbl_d      = dbl_q;
    done_d     = done_q;
    write_collision_flag_d     = write_collision_flag_q;
    done_arm_d = done_arm_q;
    write_collision_flag_arm_d = write_collision_flag_arm_q;
    sh_d       = sh_q;
    tx_hold_d  = tx_hold_q;
    last_rx_d  = last_rx_q;
    out_d      = out_q;
    sck_d      = sck_q;
    sck_prev_d = sck_i;
    div_d      = div_q;
    edge_d     = edge_q;
    bit_d      = bit_q;
    byte_done  = 1'b0;
    sample     = 1'b0;
    leading    = 1'b0;
    if (ctrl_wr) begin
      ctrl_d = reg_wdata;
    end
    if (stat_wr) begin
      dbl_d = reg_wdata[`SPI_STAT_DBL];
    end
    // clears: vector taken, or status read with flag set then data access
    if (stat_rd) begin
      done_arm_d = done_q;
      write_collision_flag_arm_d = write_collision_flag_q;
    end
    if (irq_ack) begin
      done_d = 1'b0;
    end
    if (data_rd || data_wr) begin
      if (done_arm_q || write_collision_flag_arm_q) begin
        done_d = 1'b0;
      end
      if (write_collision_flag_arm_q) begin
        write_collision_flag_d = 1'b0;
      end
      done_arm_d = 1'b0;
      write_collision_flag_arm_d = 1'b0;
    end
    if (rd_pop) begin
      last_rx_d = fifo_out_data;
    end
    // transmit is single buffered: a write in flight is dropped
    if (data_wr) begin
      if (busy) begin
        write_collision_flag_d = 1'b1;
      end else begin
        sh_d      = reg_wdata;
        tx_hold_d = reg_wdata;
        out_d     = head_bit(reg_wdata, lsb_first);
        if (enabled && master) begin
          state_d = spi_port_pkg::ST_M_WAIT;
        end
      end
    end
    case (state_q)
      spi_port_pkg::ST_IDLE: begin
        sck_d = clock_idle_level;
        bit_d = 3'h0;
        if (enabled && !master && !ss_n_i && !data_wr) begin
          state_d = spi_port_pkg::ST_S_ACTIVE;
          out_d   = head_bit(sh_q, lsb_first);
        end
      end
      spi_port_pkg::ST_M_WAIT: begin
        // holds the start while the receive buffer has no room
        div_d  = 7'h00;
        edge_d = 4'h0;
        if (fifo_in_ready) begin
          state_d = spi_port_pkg::ST_M_SHIFT;
        end
      end
      spi_port_pkg::ST_M_SHIFT: begin
        div_d = div_q + 7'h01;
        if (div_q == half_period(dbl_q, ctrl_q[`SPI_CTRL_RATE_HI:`SPI_CTRL_RATE_LO]) - 7'h01) begin
          div_d   = 7'h00;
          sck_d   = !sck_q;
          edge_d  = edge_q + 4'h1;
          leading = !edge_q[0];
          sample  = leading ^ clock_sample_phase;
          if (sample) begin
            sh_d = shift_in(sh_q, miso_i, lsb_first);
          end else begin
            out_d = head_bit(sh_q, lsb_first);
          end
          if (edge_q == `SPI_EDGE_LAST) begin
            byte_done = 1'b1;
            state_d   = spi_port_pkg::ST_IDLE;
          end
        end
      end
      spi_port_pkg::ST_S_ACTIVE: begin
        if (!enabled || master || ss_n_i) begin
          // partial bits are dropped and the byte to send is restored
          state_d = spi_port_pkg::ST_IDLE;
          bit_d   = 3'h0;
          sh_d    = tx_hold_q;
        end else if (sck_i != sck_prev_q) begin
          leading = (sck_i != clock_idle_level);
          sample  = leading ^ clock_sample_phase;
          if (sample) begin
            sh_d  = shift_in(sh_q, mosi_i, lsb_first);
            bit_d = bit_q + 3'h1;
            if (bit_q == `SPI_BITS_LAST) begin
              byte_done = 1'b1;
            end
          end else begin
            out_d = head_bit(sh_q, lsb_first);
          end
        end
      end
      default: begin
        state_d = spi_port_pkg::ST_IDLE;
      end
    endcase
    if (state_q != spi_port_pkg::ST_S_ACTIVE && state_q != spi_port_pkg::ST_IDLE && (!enabled || !master)) begin
      state_d = spi_port_pkg::ST_IDLE;
    end
    if (byte_done) begin
      tx_hold_d = sh_d;
    end
    if (forced_slave) begin
      ctrl_d[`SPI_CTRL_MASTER] = 1'b0;
      state_d                  = spi_port_pkg::ST_IDLE;
      sck_d                    = clock_idle_level;
    end
    // sets win over any clear in the same cycle
    if (byte_done || forced_slave) begin
      done_d = 1'b1;
    end
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SPI_REG_CTRL:   rdata_d = ctrl_q;
        `SPI_REG_STATUS: rdata_d = {done_q, write_collision_flag_q, 5'h00, dbl_q};
        `SPI_REG_DATA:   rdata_d = fifo_out_valid ? fifo_out_data : last_rx_q;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q    <= spi_port_pkg::ST_IDLE;
      ctrl_q     <= `SPI_CTRL_RESET;
      dbl_q      <= 1'b0;
      done_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      done_arm_q <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
      sh_q       <= 8'h00;
      tx_hold_q  <= 8'h00;
      last_rx_q  <= 8'h00;
      out_q      <= 1'b0;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      div_q      <= 7'h00;
      edge_q     <= 4'h0;
      bit_q      <= 3'h0;
      rdata_q    <= 8'h00;
    end else begin
      state_q    <= state_d;
      ctrl_q     <= ctrl_d;
      dbl_q      <= dbl_d;
      done_q     <= done_d;
      write_collision_flag_q     <= write_collision_flag_d;
      done_arm_q <= done_arm_d;
      write_collision_flag_arm_q <= write_collision_flag_arm_d;
      sh_q       <= sh_d;
      tx_hold_q  <= tx_hold_d;
      last_rx_q  <= last_rx_d;
      out_q      <= out_d;
      sck_q      <= sck_d;
      sck_prev_q <= sck_prev_d;
      div_q      <= div_d;
      edge_q     <= edge_d;
      bit_q      <= bit_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = done_q && ctrl_q[`SPI_CTRL_IRQ_EN] && global_irq_en;

  // pin overrides; a disabled port leaves the user directions in force
  always_comb begin
    mosi_o  = out_q;
    miso_o  = out_q;
    sck_o   = sck_q;
    ss_n_o  = ss_gpio_out;
    mosi_oe = mosi_dir;
    miso_oe = miso_dir;
    sck_oe  = sck_dir;
    ss_n_oe = ss_dir;
    if (enabled && master) begin
      miso_oe = 1'b0;
    end else if (enabled) begin
      mosi_oe = 1'b0;
      sck_oe  = 1'b0;
      ss_n_oe = 1'b0;
      miso_oe = miso_dir && !ss_n_i;
    end
  end

endmodule // spi_master_slave_port

// File: tb/spi_port_asserts.sv
// assertion checker for the serial port, bound to the top module
`timescale 1ns/1ps
module spi_port_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // interrupt
  input wire logic       global_irq_en,
  input wire logic       irq,
  // pins
  input wire logic       mosi_dir,
  input wire logic       miso_dir,
  input wire logic       sck_dir,
  input wire logic       ss_dir,
  input wire logic       ss_n_i,
  input wire logic       sck_o,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       sck_oe
);
  logic [7:0] ctl_q;
  logic       dbl_q;
  logic       en;
  logic       mst;
  assign en  = ctl_q[6];
  assign mst = ctl_q[4];
  // shadow copy; hardware clears the master bit on a forced slave
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_q <= 8'h00;
      dbl_q <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == 2'h0) ctl_q <= reg_wdata;
      if (en && mst && !ss_dir && !ss_n_i) ctl_q[4] <= 1'h0;
      if (reg_wr && reg_addr == 2'h1) dbl_q <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence force_s;
    en && mst && !ss_dir && !ss_n_i;
  endsequence
  reset_clear_a: assert property ($rose(resetn) |-> reg_rdata == 8'h00 && !irq)
    else $error("outputs not clear after reset");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without a read");
  irq_cause_a: assert property (irq |-> global_irq_en && ctl_q[7])
    else $error("interrupt without enables");
  slave_miso_a: assert property (en && !mst |-> miso_oe == (miso_dir && !ss_n_i))
    else $error("miso drive wrong in slave");
  master_pins_a: assert property (en && mst |-> !miso_oe && sck_oe == sck_dir && mosi_oe == mosi_dir)
    else $error("pin directions wrong in master");
  slave_pins_a: assert property (en && !mst |-> !mosi_oe && !sck_oe)
    else $error("pin directions wrong in slave");
  off_pins_a: assert property (!en |-> miso_oe == miso_dir && sck_oe == sck_dir)
    else $error("disabled port overrides pins");
  rate_half_a: assert property (en && mst && ctl_q[1:0] == 2'h0 && !dbl_q && $changed(sck_o) |=> $stable(sck_o))
    else $error("sck half period too short");
  forced_pins_a: assert property (force_s |=> !mosi_oe && !sck_oe)
    else $error("forced slave keeps driving");
  forced_irq_a: assert property (force_s ##1 (ctl_q[7] && global_irq_en) |-> irq)
    else $error("forced slave without interrupt");
endmodule // spi_port_asserts

bind spi_master_slave_port spi_port_asserts spi_port_asserts_inst (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en), .irq(irq),
  .mosi_dir(mosi_dir), .miso_dir(miso_dir), .sck_dir(sck_dir), .ss_dir(ss_dir), .ss_n_i(ss_n_i),
  .sck_o(sck_o), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .sck_oe(sck_oe)
);

// File: tb/spi_peer_model.sv
// external slave device facing the master port
`timescale 1ns/1ps
module spi_peer_model (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // mode {lsb first, idle level, sample phase} and bytes
  input  wire logic [2:0] mode,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'h0;
  initial rx = 8'h00;
  always @(negedge ss_n) begin
    sh = tx;
    miso = mode[2] ? tx[0] : tx[7];
  end
  // a released line shows the inverse so a stale bit never passes for data
  always @(posedge ss_n) miso = ~miso;
  always @(sck) if (!ss_n) begin
    if ((sck != mode[1]) ^ mode[0]) begin
      sh = mode[2] ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      rx = sh;
    end else
      miso = mode[2] ? sh[0] : sh[7];
  end
endmodule // spi_peer_model

// File: tb/testbench.sv
// self-checking bench for the serial port with a far-side peer
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       resetn = 1'h0;
  logic [1:0] reg_addr = 2'h0;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       global_irq_en = 1'h0;
  logic       irq_ack = 1'h0;
  logic       irq;
  logic       miso_dir = 1'h1;
  logic       ss_dir = 1'h1;
  logic       ss_gpio_out = 1'h1;
  logic       tb_sck = 1'h0;
  logic       tb_mosi = 1'h0;
  logic       tb_ss = 1'h1;
  logic [2:0] peer_mode = 3'h0;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] peer_rx;
  logic       peer_miso;
  logic       mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_n_o, ss_n_oe;
  logic [7:0] d, e, r, fq[9];
  logic       b;
  logic       rd_seen = 1'h0;
  logic [7:0] exp_q[$];
  integer     seed = 32'h988673B7;
  int         n_errors = 0;
  int         total_checks = 0;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : peer_miso;
  wire sck_w  = sck_oe ? sck_o : tb_sck;
  wire ss_w   = ss_n_oe ? ss_n_o : tb_ss;

  spi_master_slave_port #(.FIFO_DEPTH(8)) spi_master_slave_port_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
    .irq_ack(irq_ack), .irq(irq), .mosi_dir(1'h1), .miso_dir(miso_dir), .sck_dir(1'h1),
    .ss_dir(ss_dir), .ss_gpio_out(ss_gpio_out), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe(sck_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  spi_peer_model spi_peer_model_inst (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
    .miso(peer_miso), .mode(peer_mode), .tx(peer_tx), .rx(peer_rx));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] x);
    @(negedge clk);
    exp_q.push_back(x);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
  endtask

  // read data lands one cycle after the strobe
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);

  // selects the peer then starts a byte; waits a fixed number of cycles, never for the flag
  task automatic mxfer(input logic [7:0] v, input int w);
    peer_tx = $random(seed);
    ss_gpio_out = 1'h0;
    wr(2'h2, v);
    repeat (w) @(negedge clk);
  endtask

  task automatic mbyte;
    d = $random(seed);
    mxfer(d, 40);
    ss_gpio_out = 1'h1;
    chk("peer_rx", d, peer_rx);
    rd(2'h1, 8'h80);
    rd(2'h2, peer_tx);
  endtask

  // bit-banged external master, phases of three system clocks
  task automatic sbit(input logic v, output logic s);
    tb_mosi = v;
    repeat (3) @(negedge clk);
    s = miso_w;
    tb_sck = 1'h1;
    repeat (3) @(negedge clk);
    tb_sck = 1'h0;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'h1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    for (int m = 0; m < 8; m++) begin
      peer_mode = m[2:0];
      wr(2'h0, {1'h0, 1'h1, m[2], 1'h1, m[1:0], 2'h0});
      mbyte();
    end
    peer_mode = 3'h0;
    wr(2'h0, 8'h51);
    d = $random(seed);
    mxfer(d, 0);
    wr(2'h2, ~d);
    repeat (100) @(negedge clk);
    rd(2'h1, 8'h40);
    repeat (40) @(negedge clk);
    ss_gpio_out = 1'h1;
    chk("peer_rx", d, peer_rx);
    rd(2'h1, 8'hC0);
    rd(2'h2, peer_tx);
    rd(2'h1, 8'h00);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h53);
    d = $random(seed);
    mxfer(d, 498);
    rd(2'h1, 8'h01);
    repeat (20) @(negedge clk);
    rd(2'h1, 8'h81);
    rd(2'h2, peer_tx);
    ss_gpio_out = 1'h1;
    chk("peer_rx", d, peer_rx);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'hD0);
    mxfer($random(seed), 40);
    chk("irq", 8'h00, {7'h00, irq});
    global_irq_en = 1'h1;
    @(negedge clk);
    chk("irq", 8'h01, {7'h00, irq});
    irq_ack = 1'h1;
    @(negedge clk);
    irq_ack = 1'h0;
    @(negedge clk);
    chk("irq", 8'h00, {7'h00, irq});
    ss_gpio_out = 1'h1;
    rd(2'h2, peer_tx);
    for (int k = 0; k < 9; k++) begin
      e = $random(seed);
      mxfer(e, 40);
      fq[k] = peer_tx;
      if (k < 8) begin
        ss_gpio_out = 1'h1;
        r = e;
        @(negedge clk);
      end
    end
    chk("peer_rx", r, peer_rx);
    for (int k = 0; k < 9; k++) begin
      if (k == 8) repeat (40) @(negedge clk);
      rd(2'h2, fq[k]);
    end
    ss_gpio_out = 1'h1;
    rd(2'h1, 8'h80);
    rd(2'h2, fq[8]);
    rd(2'h1, 8'h00);
    ss_dir = 1'h0;
    tb_ss = 1'h0;
    repeat (3) @(negedge clk);
    rd(2'h0, 8'hC0);
    rd(2'h1, 8'h80);
    rd(2'h2, fq[8]);
    tb_ss = 1'h1;
    wr(2'h0, 8'h40);
    d = $random(seed);
    wr(2'h2, d);
    tb_ss = 1'h0;
    for (int i = 0; i < 3; i++) sbit(1'h1, b);
    tb_ss = 1'h1;
    @(negedge clk);
    tb_ss = 1'h0;
    e = $random(seed);
    for (int i = 7; i >= 0; i--) begin
      sbit(e[i], b);
      r[i] = b;
    end
    tb_ss = 1'h1;
    chk("miso", d, r);
    repeat (3) @(negedge clk);
    rd(2'h1, 8'h80);
    rd(2'h2, e);
    wr(2'h0, 8'h00);
    tb_ss = 1'h0;
    wr(2'h2, 8'hA5);
    repeat (40) @(negedge clk);
    rd(2'h1, 8'h00);
    repeat (2) @(negedge clk);
    end_of_test();
  end

  // whole run is about 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule // testbench
